/* File: core/event_counter.sv */
// wrapping 16-bit event counter
// assumes bump is a one-cycle pulse on the same clock
`timescale 1ns/10ps
module event_counter (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// event
	input  wire logic        bump,
	output logic      [15:0] count
);

	typedef struct packed {
		logic [15:0] value;
	} count_s;

	count_s s;
	count_s next_s;

	always_comb begin
		next_s = s;
		if (bump) begin
			next_s.value = s.value + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s.value <= fieldbus_bank_pkg::COUNT_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign count = s.value;

endmodule // event_counter

/* File: core/fieldbus_bank.sv */
// status and command register bank of the motor starter
// assumes all inputs come from logic on MCLK, single-word AHB-Lite transfers
//
// Overview of operation
// RQ1 - status bits 0-3: running, enabled, inching, test
// RQ2 - bits 4-7: ramp up, full, bypass, ramp down
// RQ3 - bits 8-11: remote, braking, reversal, reverse
// RQ4 - bits 12-13: start delay, stop delay
// RQ5 - bit 14 alarm, bit 15 fault
// RQ6 - one command word per accessory slot
// RQ7 - command bits 0-4: run, enable, inching, ccw, remote
// RQ8 - fault reset on bit 7 rise only
// RQ9 - inactive source run and inching forced zero
// RQ10 - outputs one to three from bits 0-2
// RQ11 - 10-bit analog value, linear full scale
// RQ12 - controller status item, 0 to 6
// RQ13 - node state and comm status, read-only
// RQ14 - four 16-bit frame and error counters
// RQ15 - controller status code meanings
// RQ16 - frame counters count every frame, wrapping
// RQ17 - stopped node serves management object only
// RQ18 - reserved command bits ignored, read zero
`timescale 1ns/10ps
module fieldbus_bank (
	// clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST,
	// ahb-lite slave
	input  wire logic        HSEL,
	input  wire logic [7:0]  HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic        HREADY,
	input  wire logic [31:0] HWDATA,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// motor state
	input  wire logic        MOTOR_RUNNING,
	input  wire logic        ENABLED_ALL,
	input  wire logic        INCHING_ACTIVE,
	input  wire logic        INITIAL_TEST,
	input  wire logic        RAMP_UP,
	input  wire logic        FULL_VOLTAGE,
	input  wire logic        BYPASS_CLOSED,
	input  wire logic        RAMP_DOWN,
	input  wire logic        LOCAL_REMOTE_SELECT,
	input  wire logic        BRAKING,
	input  wire logic        DIRECTION_REVERSAL,
	input  wire logic        REVERSE_ROTATION,
	input  wire logic        START_DELAY,
	input  wire logic        STOP_DELAY,
	input  wire logic        ALARM_ACTIVE,
	input  wire logic        FAULT_ACTIVE,
	// command source
	input  wire logic [1:0]  ACTIVE_SOURCE,
	// can interface state
	input  wire logic [2:0]  CONTROLLER_STATUS,
	input  wire logic [2:0]  COMM_STATUS,
	input  wire logic [2:0]  NODE_STATE,
	input  wire logic        RX_FRAME,
	input  wire logic        TX_FRAME,
	input  wire logic        LOST_MESSAGE,
	// commands to the starter
	output logic             RUN_START,
	output logic             GENERAL_ENABLE,
	output logic             INCHING_RUN,
	output logic             DIRECTION_CCW,
	output logic             REMOTE_REQUEST,
	output logic             FAULT_RESET,
	output logic             OBJECTS_SERVED,
	// outputs
	output logic             DIGITAL_OUTPUT_ONE,
	output logic             DIGITAL_OUTPUT_TWO,
	output logic             DIGITAL_OUTPUT_THREE,
	output logic      [9:0]  ANALOG_OUTPUT,
	// interrupt
	output logic             IRQ
);

	typedef struct packed {
		fieldbus_bank_pkg::bus_phase_e phase;
		logic [7:0]  addr;
		logic [15:0] cmd_one;
		logic [15:0] cmd_two;
		logic [15:0] dout_image;
		logic [9:0]  aout;
		logic [1:0]  last_reset;
		logic [2:0]  last_ctrl;
		logic [2:0]  irq_status;
		logic [2:0]  irq_mask;
		logic [31:0] rdata;
		logic        ready;
		logic        run;
		logic        enable;
		logic        inching;
		logic        ccw;
		logic        remote;
		logic        fault_reset;
		logic        served;
		logic        irq;
		logic [2:0]  dout;
		logic [9:0]  aout_pin;
	} bank_s;

	bank_s       s;
	bank_s       next_s;
	logic [15:0] status_vec;
	logic [15:0] cnt [4];
	logic [3:0]  bump;
	logic        bus_off_entry;
	logic        accept;
	logic        rise_one;
	logic        rise_two;
	logic [15:0] sel_word;
	logic [31:0] rd;

	// status word assembled from live motor state
	assign status_vec = {FAULT_ACTIVE, ALARM_ACTIVE,          // RQ5
		STOP_DELAY, START_DELAY,                           // RQ4
		REVERSE_ROTATION, DIRECTION_REVERSAL,              // RQ3
		BRAKING, LOCAL_REMOTE_SELECT,                      // RQ3
		RAMP_DOWN, BYPASS_CLOSED, FULL_VOLTAGE, RAMP_UP,   // RQ2
		INITIAL_TEST, INCHING_ACTIVE, ENABLED_ALL,         // RQ1
		MOTOR_RUNNING};                                    // RQ1

	// count only the entry into bus off, not the time spent there
	assign bus_off_entry = (CONTROLLER_STATUS == fieldbus_bank_pkg::CTRL_BUS_OFF) &&
		(s.last_ctrl != fieldbus_bank_pkg::CTRL_BUS_OFF); // RQ15

	assign bump   = {LOST_MESSAGE, bus_off_entry, TX_FRAME, RX_FRAME}; // RQ16
	assign accept = HSEL & HTRANS[1] & HREADY;

	// rx, tx, bus off, lost message
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_count
			event_counter u_count (
				.clk   (MCLK),
				.rst   (RST),
				.bump  (bump[gi]),
				.count (cnt[gi])
			); // RQ14
		end
	endgenerate

	always_comb begin
		next_s   = s;
		rd       = 32'h0000_0000;
		sel_word = 16'h0000;
		rise_one = s.cmd_one[fieldbus_bank_pkg::CMD_RESET_BIT] & ~s.last_reset[0];
		rise_two = s.cmd_two[fieldbus_bank_pkg::CMD_RESET_BIT] & ~s.last_reset[1];

		// data phase of the previous bus transfer
		case (s.phase)
			fieldbus_bank_pkg::BUS_WRITE: begin
				case (s.addr)
					fieldbus_bank_pkg::CMD_ONE_OFF: begin
						next_s.cmd_one = HWDATA[15:0] & fieldbus_bank_pkg::CMD_WRITE_MASK; // RQ18
					end
					fieldbus_bank_pkg::CMD_TWO_OFF: begin
						next_s.cmd_two = HWDATA[15:0] & fieldbus_bank_pkg::CMD_WRITE_MASK; // RQ18
					end
					fieldbus_bank_pkg::DOUT_IMAGE_OFF: begin
						next_s.dout_image = HWDATA[15:0];
					end
					fieldbus_bank_pkg::AOUT_VALUE_OFF: begin
						next_s.aout = HWDATA[9:0]; // RQ11
					end
					fieldbus_bank_pkg::IRQ_MASK_OFF: begin
						next_s.irq_mask = HWDATA[2:0];
					end
					default: begin
					end
				endcase
			end
			fieldbus_bank_pkg::BUS_READ: begin
			end
			fieldbus_bank_pkg::BUS_IDLE: begin
			end
			default: begin
			end
		endcase

		// a stale run request from a slot that lost control must never restart the motor
		if (ACTIVE_SOURCE != fieldbus_bank_pkg::SRC_SLOT_ONE) begin
			next_s.cmd_one[fieldbus_bank_pkg::CMD_RUN_BIT]     = 1'b0; // RQ9
			next_s.cmd_one[fieldbus_bank_pkg::CMD_INCHING_BIT] = 1'b0; // RQ9
		end
		if (ACTIVE_SOURCE != fieldbus_bank_pkg::SRC_SLOT_TWO) begin
			next_s.cmd_two[fieldbus_bank_pkg::CMD_RUN_BIT]     = 1'b0; // RQ9
			next_s.cmd_two[fieldbus_bank_pkg::CMD_INCHING_BIT] = 1'b0; // RQ9
		end

		// address phase; read data is captured here and shown in the data phase
		next_s.phase = fieldbus_bank_pkg::BUS_IDLE;
		next_s.rdata = 32'h0000_0000;
		if (accept) begin
			next_s.addr  = HADDR;
			next_s.phase = HWRITE ? fieldbus_bank_pkg::BUS_WRITE : fieldbus_bank_pkg::BUS_READ;
			case (HADDR)
				fieldbus_bank_pkg::STATUS_WORD_OFF:  rd[15:0] = status_vec;    // RQ1
				fieldbus_bank_pkg::CMD_ONE_OFF:      rd[15:0] = s.cmd_one;     // RQ6
				fieldbus_bank_pkg::CMD_TWO_OFF:      rd[15:0] = s.cmd_two;     // RQ6
				fieldbus_bank_pkg::DOUT_IMAGE_OFF:   rd[15:0] = s.dout_image;
				fieldbus_bank_pkg::AOUT_VALUE_OFF:   rd[9:0]  = s.aout;
				fieldbus_bank_pkg::CTRL_STATUS_OFF:  rd[2:0]  = CONTROLLER_STATUS; // RQ12
				fieldbus_bank_pkg::RX_COUNT_OFF:     rd[15:0] = cnt[0];
				fieldbus_bank_pkg::TX_COUNT_OFF:     rd[15:0] = cnt[1];
				fieldbus_bank_pkg::BUSOFF_COUNT_OFF: rd[15:0] = cnt[2];
				fieldbus_bank_pkg::LOST_COUNT_OFF:   rd[15:0] = cnt[3];
				fieldbus_bank_pkg::COMM_STATUS_OFF:  rd[2:0]  = COMM_STATUS;  // RQ13
				fieldbus_bank_pkg::NODE_STATE_OFF:   rd[2:0]  = NODE_STATE;   // RQ13
				fieldbus_bank_pkg::IRQ_STATUS_OFF:   rd[2:0]  = s.irq_status;
				fieldbus_bank_pkg::IRQ_MASK_OFF:     rd[2:0]  = s.irq_mask;
				default:                             rd       = 32'h0000_0000;
			endcase
			if (!HWRITE) begin
				next_s.rdata = rd;
				if (HADDR == fieldbus_bank_pkg::IRQ_STATUS_OFF) begin
					next_s.irq_status = 3'h0;
				end
			end
		end

		// fault reset only on a fresh rising edge, never on a held level
		next_s.last_reset  = {s.cmd_two[fieldbus_bank_pkg::CMD_RESET_BIT],
			s.cmd_one[fieldbus_bank_pkg::CMD_RESET_BIT]};
		next_s.fault_reset = (rise_one | rise_two) & FAULT_ACTIVE; // RQ8
		next_s.last_ctrl   = CONTROLLER_STATUS;

		// events set after the read clear so a same-cycle event survives
		next_s.irq_status[fieldbus_bank_pkg::IRQ_FAULT_RESET] =
			next_s.irq_status[fieldbus_bank_pkg::IRQ_FAULT_RESET] | next_s.fault_reset;
		next_s.irq_status[fieldbus_bank_pkg::IRQ_BUS_OFF] =
			next_s.irq_status[fieldbus_bank_pkg::IRQ_BUS_OFF] | bus_off_entry;
		next_s.irq_status[fieldbus_bank_pkg::IRQ_LOST] =
			next_s.irq_status[fieldbus_bank_pkg::IRQ_LOST] | LOST_MESSAGE;
		next_s.irq = |(next_s.irq_status & next_s.irq_mask);

		// commands follow the active source only
		case (ACTIVE_SOURCE)
			fieldbus_bank_pkg::SRC_SLOT_ONE: sel_word = s.cmd_one;
			fieldbus_bank_pkg::SRC_SLOT_TWO: sel_word = s.cmd_two;
			default:                         sel_word = 16'h0000;
		endcase
		next_s.run     = sel_word[fieldbus_bank_pkg::CMD_RUN_BIT];     // RQ7
		next_s.enable  = sel_word[fieldbus_bank_pkg::CMD_ENABLE_BIT];  // RQ7
		next_s.inching = sel_word[fieldbus_bank_pkg::CMD_INCHING_BIT]; // RQ7
		next_s.ccw     = sel_word[fieldbus_bank_pkg::CMD_DIR_BIT];     // RQ7
		next_s.remote  = sel_word[fieldbus_bank_pkg::CMD_REMOTE_BIT];  // RQ7

		// pdo and sdo traffic only in operational or pre-operational
		next_s.served = (NODE_STATE == fieldbus_bank_pkg::NODE_OPER) ||
			(NODE_STATE == fieldbus_bank_pkg::NODE_PREOP); // RQ17

		next_s.dout     = s.dout_image[2:0]; // RQ10
		next_s.aout_pin = s.aout;            // RQ11
		next_s.ready    = 1'b1;
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			s            <= '0;
			s.cmd_one    <= fieldbus_bank_pkg::CMD_RESET;
			s.cmd_two    <= fieldbus_bank_pkg::CMD_RESET;
			s.dout_image <= fieldbus_bank_pkg::DOUT_RESET;
			s.aout       <= fieldbus_bank_pkg::AOUT_RESET;
			s.irq_mask   <= fieldbus_bank_pkg::MASK_RESET;
			s.ready      <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign HRDATA               = s.rdata;
	assign HREADYOUT            = s.ready;
	assign HRESP                = 1'b0;
	assign RUN_START            = s.run;
	assign GENERAL_ENABLE       = s.enable;
	assign INCHING_RUN          = s.inching;
	assign DIRECTION_CCW        = s.ccw;
	assign REMOTE_REQUEST       = s.remote;
	assign FAULT_RESET          = s.fault_reset;
	assign OBJECTS_SERVED       = s.served;
	assign DIGITAL_OUTPUT_ONE   = s.dout[0];
	assign DIGITAL_OUTPUT_TWO   = s.dout[1];
	assign DIGITAL_OUTPUT_THREE = s.dout[2];
	assign ANALOG_OUTPUT        = s.aout_pin;
	assign IRQ                  = s.irq;

	// checks
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);

	sequence status_read_s;
		accept && !HWRITE && (HADDR == fieldbus_bank_pkg::STATUS_WORD_OFF);
	endsequence

	sequence reset_rise_s;
		$rose(s.cmd_one[fieldbus_bank_pkg::CMD_RESET_BIT]) && FAULT_ACTIVE;
	endsequence

	property status_read_p;
		status_read_s |=> (HRDATA[15:0] == $past(status_vec)) && (HRDATA[31:16] == 16'h0000);
	endproperty

	property reset_pulse_p;
		reset_rise_s |=> FAULT_RESET ##1 !FAULT_RESET;
	endproperty

	status_word_a: assert property (status_read_p) // RQ5
		else $error("status word read mismatch");

	fault_reset_edge_a: assert property (reset_pulse_p) // RQ8
		else $error("fault reset not a single pulse");

	reset_needs_fault_a: assert property (FAULT_RESET |-> $past(FAULT_ACTIVE)) // RQ8
		else $error("fault reset without fault");

	inactive_clear_a: assert property ((ACTIVE_SOURCE != fieldbus_bank_pkg::SRC_SLOT_ONE) |=> // RQ9
		!s.cmd_one[fieldbus_bank_pkg::CMD_RUN_BIT] && !s.cmd_one[fieldbus_bank_pkg::CMD_INCHING_BIT])
		else $error("inactive slot kept run or inching");

	reserved_zero_a: assert property (((s.cmd_one | s.cmd_two) & ~fieldbus_bank_pkg::CMD_WRITE_MASK) == 16'h0000) // RQ18
		else $error("reserved command bit set");

	dout_map_a: assert property (##2 {DIGITAL_OUTPUT_THREE, DIGITAL_OUTPUT_TWO, DIGITAL_OUTPUT_ONE} == // RQ10
		$past(s.dout_image[2:0]))
		else $error("digital outputs differ from image");

	aout_map_a: assert property (##2 ANALOG_OUTPUT == $past(s.aout)) // RQ11
		else $error("analog output differs from value");

	direction_cmd_a: assert property ((ACTIVE_SOURCE == fieldbus_bank_pkg::SRC_SLOT_TWO) |=> // RQ7
		DIRECTION_CCW == $past(s.cmd_two[fieldbus_bank_pkg::CMD_DIR_BIT]))
		else $error("direction does not follow slot two");

	rx_count_a: assert property (RX_FRAME |=> cnt[0] == 16'($past(cnt[0]) + 16'h0001)) // RQ16
		else $error("received frame not counted");

	busoff_count_a: assert property (bus_off_entry |=> cnt[2] == 16'($past(cnt[2]) + 16'h0001)) // RQ14
		else $error("bus off entry not counted");

	stopped_served_a: assert property ((NODE_STATE == fieldbus_bank_pkg::NODE_STOPPED) |=> // RQ17
		!OBJECTS_SERVED)
		else $error("objects served while stopped");

endmodule // fieldbus_bank

/* File: core/fieldbus_bank_pkg.sv */
// constants of the drive status and command bank
// assumes a 32-bit AHB-Lite slave port with byte addresses in the low eight bits
package fieldbus_bank_pkg;

	// register byte addresses
	localparam logic [7:0] STATUS_WORD_OFF  = 8'h00;
	localparam logic [7:0] CMD_ONE_OFF      = 8'h04;
	localparam logic [7:0] CMD_TWO_OFF      = 8'h08;
	localparam logic [7:0] DOUT_IMAGE_OFF   = 8'h0c;
	localparam logic [7:0] AOUT_VALUE_OFF   = 8'h10;
	localparam logic [7:0] CTRL_STATUS_OFF  = 8'h14;
	localparam logic [7:0] RX_COUNT_OFF     = 8'h18;
	localparam logic [7:0] TX_COUNT_OFF     = 8'h1c;
	localparam logic [7:0] BUSOFF_COUNT_OFF = 8'h20;
	localparam logic [7:0] LOST_COUNT_OFF   = 8'h24;
	localparam logic [7:0] COMM_STATUS_OFF  = 8'h28;
	localparam logic [7:0] NODE_STATE_OFF   = 8'h2c;
	localparam logic [7:0] IRQ_STATUS_OFF   = 8'h30;
	localparam logic [7:0] IRQ_MASK_OFF     = 8'h34;

	// reset values
	localparam logic [15:0] CMD_RESET   = 16'h0000;
	localparam logic [15:0] DOUT_RESET  = 16'h0000;
	localparam logic [9:0]  AOUT_RESET  = 10'h000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [2:0]  MASK_RESET  = 3'h0;

	// command word fields
	localparam int CMD_RUN_BIT     = 0;
	localparam int CMD_ENABLE_BIT  = 1;
	localparam int CMD_INCHING_BIT = 2;
	localparam int CMD_DIR_BIT     = 3;
	localparam int CMD_REMOTE_BIT  = 4;
	localparam int CMD_RESET_BIT   = 7;
	localparam logic [15:0] CMD_WRITE_MASK = 16'h009f;

	// command source select
	localparam logic [1:0] SRC_LOCAL    = 2'h0;
	localparam logic [1:0] SRC_SLOT_ONE = 2'h1;
	localparam logic [1:0] SRC_SLOT_TWO = 2'h2;

	// controller status codes
	localparam logic [2:0] CTRL_DISABLED  = 3'h0;
	localparam logic [2:0] CTRL_BAUD_DET  = 3'h1;
	localparam logic [2:0] CTRL_ACTIVE    = 3'h2;
	localparam logic [2:0] CTRL_WARNING   = 3'h3;
	localparam logic [2:0] CTRL_PASSIVE   = 3'h4;
	localparam logic [2:0] CTRL_BUS_OFF   = 3'h5;
	localparam logic [2:0] CTRL_NO_SUPPLY = 3'h6;

	// node state codes
	localparam logic [2:0] NODE_DISABLED = 3'h0;
	localparam logic [2:0] NODE_INIT     = 3'h1;
	localparam logic [2:0] NODE_STOPPED  = 3'h2;
	localparam logic [2:0] NODE_OPER     = 3'h3;
	localparam logic [2:0] NODE_PREOP    = 3'h4;

	// interrupt status bits
	localparam int IRQ_FAULT_RESET = 0;
	localparam int IRQ_BUS_OFF     = 1;
	localparam int IRQ_LOST        = 2;

	typedef enum logic [1:0] {
		BUS_IDLE  = 2'b00,
		BUS_WRITE = 2'b01,
		BUS_READ  = 2'b10
	} bus_phase_e;

endpackage

/* File: verif/can_side_model.sv */
// far-side model: controller state codes and frame events of the can interface
// assumes tasks are called right after a rising edge of clk
`timescale 1ns/10ps
module can_side_model (
	// clock
	input  wire logic       clk,
	// state codes
	output logic      [2:0] ctrl_status,
	output logic      [2:0] comm_status,
	output logic      [2:0] node_state,
	// frame events
	output logic            rx_frame,
	output logic            tx_frame,
	output logic            lost_message
);
	initial begin
		ctrl_status = 3'h0;
		comm_status = 3'h0;
		node_state = 3'h0;
		rx_frame = 1'b0;
		tx_frame = 1'b0;
		lost_message = 1'b0;
	end

	// codes move only on an edge, like a real controller state
	task automatic set_state(input logic [2:0] c, input logic [2:0] m, input logic [2:0] n);
		@(posedge clk);
		ctrl_status <= c;
		comm_status <= m;
		node_state <= n;
	endtask

	// back-to-back pulses, one event per cycle, to stress the counters
	task automatic pulse(input int rx, input int tx, input int lost);
		for (int i = 0; i < rx || i < tx || i < lost; i++) begin
			@(posedge clk);
			rx_frame <= (i < rx);
			tx_frame <= (i < tx);
			lost_message <= (i < lost);
		end
		@(posedge clk);
		rx_frame <= 1'b0;
		tx_frame <= 1'b0;
		lost_message <= 1'b0;
	endtask
endmodule // can_side_model

/* File: verif/fieldbus_bank_tb.sv */
// self-checking bench of the status and command bank
// assumes a zero-or-more wait ahb-lite slave; the bench is the only master
`timescale 1ns/10ps
module fieldbus_bank_tb;
	logic        mclk;
	logic        rst;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [7:0]  haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [15:0] st;
	logic [1:0]  src;
	logic [2:0]  ctrl;
	logic [2:0]  comm;
	logic [2:0]  node;
	logic        rxf;
	logic        txf;
	logic        lostf;
	logic [4:0]  cmd_out;
	logic [2:0]  dout;
	logic [9:0]  aout;
	logic        fault_rst;
	logic        served;
	logic        irq;
	int          fr_cnt;
	int          error_cnt;
	int          checks_done;

	fieldbus_bank dut (.MCLK(mclk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'b010), .HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .MOTOR_RUNNING(st[0]), .ENABLED_ALL(st[1]),
		.INCHING_ACTIVE(st[2]), .INITIAL_TEST(st[3]), .RAMP_UP(st[4]), .FULL_VOLTAGE(st[5]),
		.BYPASS_CLOSED(st[6]), .RAMP_DOWN(st[7]), .LOCAL_REMOTE_SELECT(st[8]), .BRAKING(st[9]),
		.DIRECTION_REVERSAL(st[10]), .REVERSE_ROTATION(st[11]), .START_DELAY(st[12]),
		.STOP_DELAY(st[13]), .ALARM_ACTIVE(st[14]), .FAULT_ACTIVE(st[15]), .ACTIVE_SOURCE(src),
		.CONTROLLER_STATUS(ctrl), .COMM_STATUS(comm), .NODE_STATE(node), .RX_FRAME(rxf),
		.TX_FRAME(txf), .LOST_MESSAGE(lostf), .RUN_START(cmd_out[0]), .GENERAL_ENABLE(cmd_out[1]),
		.INCHING_RUN(cmd_out[2]), .DIRECTION_CCW(cmd_out[3]), .REMOTE_REQUEST(cmd_out[4]),
		.FAULT_RESET(fault_rst), .OBJECTS_SERVED(served), .DIGITAL_OUTPUT_ONE(dout[0]),
		.DIGITAL_OUTPUT_TWO(dout[1]), .DIGITAL_OUTPUT_THREE(dout[2]), .ANALOG_OUTPUT(aout),
		.IRQ(irq));

	can_side_model part (.clk(mclk), .ctrl_status(ctrl), .comm_status(comm), .node_state(node),
		.rx_frame(rxf), .tx_frame(txf), .lost_message(lostf));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// a held level would show as many pulses here
	always @(posedge mclk) begin
		if (fault_rst === 1'b1) fr_cnt++;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// bounded wait: a stuck slave ends the run
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			error_cnt++;
			end_of_test();
		end
	endtask

	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		d = hrdata;
		// the slave never signals an error, so every data phase must end okay
		check({31'h0000_0000, hresp}, 32'h0000_0000);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] x;
		xfer(a, 1'b1, wd, x);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		xfer(a, 1'b0, 32'h0000_0000, x);
		check(x, exp);
	endtask

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		haddr = 8'h00;
		hwdata = 32'h0000_0000;
		st = 16'h0000;
		src = 2'h0;
		fr_cnt = 0;
		error_cnt = 0;
		checks_done = 0;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd(8'h04, 32'h0000_0000);
		rd(8'h08, 32'h0000_0000);
		rd(8'h0c, 32'h0000_0000);
		rd(8'h10, 32'h0000_0000);
		rd(8'h34, 32'h0000_0000);
		rd(8'h3c, 32'h0000_0000);
		wr(8'h2c, 32'h0000_ffff);
		rd(8'h2c, 32'h0000_0000);
		done("reset");
		foreach (st[i]) begin
			st <= 16'h0001 << i;
			cyc(2);
			rd(8'h00, 32'h0000_0001 << i);
		end
		st <= 16'h0000;
		done("status");
		src <= 2'h1;
		wr(8'h04, 32'hffff_ffff);
		rd(8'h04, 32'h0000_009f);
		check(cmd_out, 32'h0000_001f);
		wr(8'h08, 32'hffff_ffff);
		rd(8'h08, 32'h0000_009a);
		src <= 2'h2;
		cyc(3);
		rd(8'h04, 32'h0000_009a);
		check(cmd_out, 32'h0000_001a);
		src <= 2'h3;
		cyc(3);
		check(cmd_out, 32'h0000_0000);
		check(fr_cnt, 32'h0000_0000);
		done("command");
		src <= 2'h1;
		st <= 16'h8000;
		wr(8'h34, 32'h0000_0001);
		wr(8'h04, 32'h0000_0000);
		wr(8'h04, 32'h0000_0080);
		cyc(6);
		check(fr_cnt, 32'h0000_0001);
		check(irq, 32'h0000_0001);
		wr(8'h04, 32'h0000_0080);
		cyc(6);
		check(fr_cnt, 32'h0000_0001);
		rd(8'h30, 32'h0000_0001);
		cyc(1);
		check(irq, 32'h0000_0000);
		wr(8'h08, 32'h0000_0000);
		wr(8'h08, 32'h0000_0080);
		cyc(6);
		check(fr_cnt, 32'h0000_0002);
		st <= 16'h0000;
		rd(8'h30, 32'h0000_0001);
		done("fault reset");
		wr(8'h34, 32'h0000_0000);
		part.pulse(3, 2, 1);
		part.set_state(3'h5, 3'h0, 3'h0);
		part.set_state(3'h2, 3'h0, 3'h0);
		part.set_state(3'h5, 3'h0, 3'h0);
		cyc(2);
		rd(8'h18, 32'h0000_0003);
		rd(8'h1c, 32'h0000_0002);
		rd(8'h24, 32'h0000_0001);
		rd(8'h20, 32'h0000_0002);
		check(irq, 32'h0000_0000);
		rd(8'h30, 32'h0000_0006);
		rd(8'h30, 32'h0000_0000);
		done("counters");
		for (int i = 0; i < 7; i++) begin
			part.set_state(3'(i), 3'(i % 6), 3'(i % 5));
			cyc(2);
			rd(8'h14, 32'(i));
			rd(8'h28, 32'(i % 6));
			rd(8'h2c, 32'(i % 5));
			check(served, 32'((i % 5) == 3 || (i % 5) == 4));
		end
		done("can state");
		wr(8'h0c, 32'hffff_fff8);
		rd(8'h0c, 32'h0000_fff8);
		check(dout, 32'h0000_0000);
		wr(8'h0c, 32'h0000_0005);
		cyc(2);
		check(dout, 32'h0000_0005);
		wr(8'h10, 32'hffff_ffff);
		rd(8'h10, 32'h0000_03ff);
		check(aout, 32'h0000_03ff);
		wr(8'h10, 32'h0000_0200);
		cyc(2);
		check(aout, 32'h0000_0200);
		done("outputs");
		part.pulse(65535, 0, 0);
		cyc(2);
		rd(8'h18, 32'h0000_0002);
		done("wrap");
		end_of_test();
	end
endmodule // fieldbus_bank_tb
